/* File: sfid_top.v */
// Serial flash ID reads, parameter read and OTP security register erase/program.
// Assumes SPI pins are asynchronous to SYS_CLK and SPI clock is well below SYS_CLK/4.
// Summary of operation
// - Opcode 90h, zero address, then manufacturer and device codes MSB first.
// - Address 000001h swaps order: device code first, then manufacturer code.
// - ID codes alternate for as long as clocks run; chip select ends it.
// - Opcode 92h: address and mode bits two per clock, codes two per edge.
// - Opcode 94h: four bits per clock, four dummy clocks, codes four per edge.
// - Opcode 4Bh, four dummy bytes, then the fixed 64-bit unique number.
// - Opcode 9Fh returns manufacturer, memory type, then capacity byte.
// - Opcode 5Ah, address, eight dummy clocks, parameter data from clock 40.
// - Security erase 44h only runs with write enable latch set.
// - Three registers selected by address fields; low byte ignored or byte address.
// - Erase runs only if chip select rises right after the last address bit.
// - Erase is self-timed, busy meanwhile, write enable latch cleared after.
// - A set lock bit blocks any erase or program of that register.
// - Program 42h needs latch set; one to 256 bytes, bits only cleared.
`timescale 1ns/10ps
`include "sfid_consts.vh"

module sfid_fifo #(
  parameter W = 8,
  parameter D = 4,
  parameter A = 2
) (
  input  wire         clk,
  input  wire         rst_n,
  input  wire         flush,
  input  wire         wr_valid,
  output wire         wr_ready,
  input  wire [W-1:0] wr_data,
  output wire         rd_valid,
  input  wire         rd_ready,
  output wire [W-1:0] rd_data
);
  reg [W-1:0] mem [0:D-1];
  reg [A:0]   wp_q;
  reg [A:0]   rp_q;
  wire        empty = (wp_q == rp_q);
  wire        full  = (wp_q[A-1:0] == rp_q[A-1:0]) && (wp_q[A] != rp_q[A]);
  assign wr_ready = !full;
  assign rd_valid = !empty;
  assign rd_data  = mem[rp_q[A-1:0]];
  always @(posedge clk) begin
    if (wr_valid && !full)
      mem[wp_q[A-1:0]] <= wr_data;
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wp_q <= {(A+1){1'b0}};
      rp_q <= {(A+1){1'b0}};
    end else if (flush) begin
      wp_q <= {(A+1){1'b0}};
      rp_q <= {(A+1){1'b0}};
    end else begin
      if (wr_valid && !full)
        wp_q <= wp_q + 1'b1;
      if (rd_ready && !empty)
        rp_q <= rp_q + 1'b1;
    end
  end
endmodule

module sfid_top #(
  parameter [7:0]  MFR_CODE  = 8'h5c,  // Arbitrary neutral value
  parameter [7:0]  DEV_CODE  = 8'h13,  // Arbitrary neutral value
  parameter [7:0]  MEM_TYPE  = 8'h40,  // Arbitrary neutral value
  parameter [7:0]  CAPACITY  = 8'h14,  // Arbitrary neutral value
  parameter [63:0] UNIQUE_ID = 64'h0123456789abcdef  // Arbitrary neutral value
) (
  // System
  input  wire       SYS_CLK,
  input  wire       RESET_N,
  // SPI pins
  input  wire       SPI_CLK,
  input  wire       SPI_CS_N,
  input  wire [3:0] SPI_IO_IN,
  output wire [3:0] SPI_IO_OUT,
  output wire [3:0] SPI_IO_OE,
  // Status shared with the rest of the device
  input  wire       WRITE_ENABLE_LATCH,
  input  wire [2:0] OTP_LOCK_BITS,
  output wire       BUSY,
  output wire       WEL_CLEAR,
  output wire [7:0] CONTINUOUS_READ_MODE_BITS,
  // Security register read port for other commands
  input  wire [9:0] SECREG_RD_ADDR,
  output wire [7:0] SECREG_RD_DATA
);
  localparam [2:0] S_OPC = 3'h0, S_ADDR = 3'h1, S_MODE = 3'h2, S_DUMMY = 3'h3,
                   S_OUT = 3'h4, S_ERW = 3'h5, S_PDATA = 3'h6, S_IGN = 3'h7;

  function [3:0] lanes(input [7:0] op);
    case (op)
      `SFID_OP_MDID2: lanes = 4'h2;
      `SFID_OP_MDID4: lanes = 4'h4;
      default:        lanes = 4'h1;
    endcase
  endfunction

  function [23:0] shin(input [23:0] a, input [3:0] io, input [3:0] w);
    case (w)
      4'h2:    shin = {a[21:0], io[1:0]};
      4'h4:    shin = {a[19:0], io[3:0]};
      default: shin = {a[22:0], io[0]};
    endcase
  endfunction

  // Single lane drives IO1, dual IO1:IO0, quad all four
  function [3:0] emit(input [7:0] b, input [3:0] w);
    case (w)
      4'h2:    emit = {2'h0, b[7:6]};
      4'h4:    emit = b[7:4];
      default: emit = {2'h0, b[7], 1'b0};
    endcase
  endfunction

  function [5:0] div_clks(input [5:0] bits, input [3:0] w);
    case (w)
      4'h2:    div_clks = bits >> 1;
      4'h4:    div_clks = bits >> 2;
      default: div_clks = bits;
    endcase
  endfunction

  function [7:0] sfdp(input [7:0] i);
    case (i)
      8'h00:   sfdp = `SFID_SIG0;
      8'h01:   sfdp = `SFID_SIG1;
      8'h02:   sfdp = `SFID_SIG2;
      8'h03:   sfdp = `SFID_SIG3;
      default: sfdp = `SFID_ERASED;
    endcase
  endfunction

  // Two-stage synchronisers; third stage only for edge finding
  reg [2:0] sck_q;
  reg [1:0] cs_q;
  reg [3:0] io1_q;
  reg [3:0] io2_q;
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sck_q <= 3'h0;
      cs_q  <= 2'h3;
      io1_q <= 4'h0;
      io2_q <= 4'h0;
    end else begin
      sck_q <= {sck_q[1:0], SPI_CLK};
      cs_q  <= {cs_q[0], SPI_CS_N};
      io1_q <= SPI_IO_IN;
      io2_q <= io1_q;
    end
  end
  reg  cs_d_q;
  wire cs_high  = cs_q[1];
  wire cs_rise  = cs_q[1] && !cs_d_q;
  wire sck_rise = sck_q[1] && !sck_q[2] && !cs_high;
  wire sck_fall = !sck_q[1] && sck_q[2] && !cs_high;

  reg [2:0]   state_q;
  reg [7:0]   cmd_q;
  reg [5:0]   left_q;
  reg [23:0]  addr_q;
  reg [7:0]   mode_q;
  reg [7:0]   pbyte_q;
  reg [2:0]   pbit_q;
  reg         pgot_q;
  reg [7:0]   paddr_q;
  reg [255:0] pmask_q;
  reg         busy_q;
  reg         erase_q;
  reg [1:0]   wbase_q;
  reg [7:0]   widx_q;
  reg         wclr_q;

  wire [3:0]  w_in   = lanes(cmd_q);
  wire [7:0]  nopc   = {cmd_q[6:0], io2_q[0]};
  wire [23:0] naddr  = shin(addr_q, io2_q, w_in);
  wire [23:0] nmode  = shin({16'h0, mode_q}, io2_q, w_in);
  wire [7:0]  nbyte  = {pbyte_q[6:0], io2_q[0]};
  wire        last   = (left_q == 6'h01);
  wire [3:0]  sel    = addr_q[15:12];
  wire [1:0]  slot   = sel[1:0] - 2'h1;
  wire        sec_ok = (addr_q[23:16] == `SFID_SEC_HI) && (addr_q[11:8] == `SFID_SEC_LO) &&
                       (sel >= `SFID_SEC_FIRST) && (sel <= `SFID_SEC_LAST) &&
                       !OTP_LOCK_BITS[slot] && WRITE_ENABLE_LATCH;
  wire        go_erase = cs_rise && (state_q == S_ERW) && sec_ok && !busy_q;
  wire        go_prog  = cs_rise && (state_q == S_PDATA) && pgot_q &&
                         (pbit_q == 3'h0) && sec_ok && !busy_q;
  wire        pb_we    = sck_rise && (state_q == S_PDATA) && (pbit_q == 3'h7);

  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      cs_d_q  <= 1'b1;
      state_q <= S_OPC;
      cmd_q   <= 8'h00;
      left_q  <= `SFID_OPC_BITS;
      addr_q  <= 24'h0;
      mode_q  <= 8'h00;
      pbyte_q <= 8'h00;
      pbit_q  <= 3'h0;
      pgot_q  <= 1'b0;
      paddr_q <= 8'h00;
      pmask_q <= 256'h0;
    end else begin
      cs_d_q <= cs_high;
      if (cs_high) begin
        state_q <= S_OPC;
        cmd_q   <= 8'h00;
        left_q  <= `SFID_OPC_BITS;
        pbit_q  <= 3'h0;
        pgot_q  <= 1'b0;
      end else if (sck_rise) begin
        left_q <= left_q - 6'h01;
        case (state_q)
          S_OPC: begin
            cmd_q <= nopc;
            if (last) begin
              left_q  <= div_clks(`SFID_ADDR_BITS, lanes(nopc));
              state_q <= S_IGN;
              if (!busy_q) begin
                case (nopc)
                  `SFID_OP_MDID, `SFID_OP_MDID2, `SFID_OP_MDID4, `SFID_OP_SFDP,
                  `SFID_OP_SERASE, `SFID_OP_SPROG: state_q <= S_ADDR;
                  `SFID_OP_UID: begin
                    state_q <= S_DUMMY;
                    left_q  <= `SFID_UID_CLKS;
                  end
                  `SFID_OP_JID: state_q <= S_OUT;
                  default: state_q <= S_IGN;
                endcase
              end
              if (nopc == `SFID_OP_SPROG && !busy_q)
                pmask_q <= 256'h0;
            end
          end
          S_ADDR: begin
            addr_q <= naddr;
            if (last) begin
              case (cmd_q)
                `SFID_OP_MDID2, `SFID_OP_MDID4: begin
                  state_q <= S_MODE;
                  left_q  <= div_clks(`SFID_MODE_BITS, w_in);
                end
                `SFID_OP_SFDP: begin
                  state_q <= S_DUMMY;
                  left_q  <= `SFID_SFDP_CLKS;
                end
                `SFID_OP_SERASE: state_q <= S_ERW;
                `SFID_OP_SPROG: begin
                  state_q <= S_PDATA;
                  paddr_q <= naddr[7:0];
                end
                default: state_q <= S_OUT;
              endcase
            end
          end
          S_MODE: begin
            mode_q <= nmode[7:0];
            if (last) begin
              state_q <= (cmd_q == `SFID_OP_MDID4) ? S_DUMMY : S_OUT;
              left_q  <= `SFID_QDUMMY_CLKS;
            end
          end
          S_DUMMY: if (last) state_q <= S_OUT;
          S_ERW: state_q <= S_IGN;
          S_PDATA: begin
            pbyte_q <= nbyte;
            pbit_q  <= pbit_q + 3'h1;
            if (pb_we) begin
              pgot_q           <= 1'b1;
              pmask_q[paddr_q] <= 1'b1;
              paddr_q          <= paddr_q + 8'h01;
            end
          end
          default: state_q <= state_q;
        endcase
      end
    end
  end

  // Page buffer and OTP array are plain memories without reset
  reg [7:0] pbuf [0:255];
  reg [7:0] sec_mem [0:767];
  reg [7:0] rd_q;
  always @(posedge SYS_CLK) begin
    if (pb_we)
      pbuf[paddr_q] <= nbyte;
    if (busy_q && (erase_q || pmask_q[widx_q]))
      sec_mem[{wbase_q, widx_q}] <= erase_q ? `SFID_ERASED :
                                    (sec_mem[{wbase_q, widx_q}] & pbuf[widx_q]);
    rd_q <= sec_mem[SECREG_RD_ADDR];
  end

  // Self-timed walk over one register; latency is one pass of 256 bytes
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      busy_q  <= 1'b0;
      erase_q <= 1'b0;
      wbase_q <= 2'h0;
      widx_q  <= 8'h00;
      wclr_q  <= 1'b0;
    end else begin
      wclr_q <= 1'b0;
      if (go_erase || go_prog) begin
        busy_q  <= 1'b1;
        erase_q <= go_erase;
        wbase_q <= slot;
        widx_q  <= 8'h00;
      end else if (busy_q) begin
        widx_q <= widx_q + 8'h01;
        if (widx_q == `SFID_LAST_BYTE) begin
          busy_q <= 1'b0;
          wclr_q <= 1'b1;
        end
      end
    end
  end

  // Producer prefetches output bytes; FIFO ready stalls it
  reg  [7:0] pidx_q;
  reg  [7:0] src;
  wire       f_ready;
  wire       f_valid;
  wire [7:0] f_data;
  wire       pop;
  wire       in_out = (state_q == S_OUT) && !cs_high;
  always @* begin
    case (cmd_q)
      `SFID_OP_UID:  src = UNIQUE_ID[8'd63 - {pidx_q[2:0], 3'h0} -: 8];
      `SFID_OP_JID:  src = (pidx_q == 8'h00) ? MFR_CODE :
                           (pidx_q == 8'h01) ? MEM_TYPE : CAPACITY;
      `SFID_OP_SFDP: src = sfdp(addr_q[7:0] + pidx_q);
      default:       src = (pidx_q[0] ^ (addr_q == `SFID_SWAP_ADDR)) ?
                           DEV_CODE : MFR_CODE;
    endcase
  end
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N)
      pidx_q <= 8'h00;
    else if (!in_out)
      pidx_q <= 8'h00;
    else if (f_ready)
      pidx_q <= (cmd_q == `SFID_OP_JID && pidx_q == `SFID_JID_LAST) ? 8'h00 :
                pidx_q + 8'h01;
  end

  sfid_fifo #(.W(8), .D(4), .A(2)) u_fifo (
    .clk      (SYS_CLK),
    .rst_n    (RESET_N),
    .flush    (!in_out),
    .wr_valid (in_out),
    .wr_ready (f_ready),
    .wr_data  (src),
    .rd_valid (f_valid),
    .rd_ready (pop),
    .rd_data  (f_data)
  );

  // Serializer: new lanes on every falling SPI edge
  reg  [7:0] osh_q;
  reg  [3:0] ocnt_q;
  reg  [3:0] io_q;
  reg  [3:0] oe_q;
  wire [7:0] ob = f_valid ? f_data : `SFID_ERASED;
  assign pop = sck_fall && in_out && (ocnt_q == 4'h0);
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      osh_q  <= 8'h00;
      ocnt_q <= 4'h0;
      io_q   <= 4'h0;
      oe_q   <= 4'h0;
    end else if (!in_out) begin
      ocnt_q <= 4'h0;
      oe_q   <= 4'h0;
    end else begin
      oe_q <= (w_in == 4'h4) ? 4'hf : (w_in == 4'h2) ? 4'h3 : 4'h2;
      if (sck_fall) begin
        if (ocnt_q == 4'h0) begin
          io_q   <= emit(ob, w_in);
          osh_q  <= ob << w_in;
          ocnt_q <= 4'h8 - w_in;
        end else begin
          io_q   <= emit(osh_q, w_in);
          osh_q  <= osh_q << w_in;
          ocnt_q <= ocnt_q - w_in;
        end
      end
    end
  end

  assign SPI_IO_OUT                = io_q;
  assign SPI_IO_OE                 = oe_q;
  assign BUSY                      = busy_q;
  assign WEL_CLEAR                 = wclr_q;
  assign CONTINUOUS_READ_MODE_BITS = mode_q;
  assign SECREG_RD_DATA            = rd_q;
endmodule

/* File: sfid_consts.vh */
// Constants for the ID and security register command block.
// Assumes one include per compile unit; guarded against repeats.
`ifndef SFID_CONSTS_VH
`define SFID_CONSTS_VH
`define SFID_OP_MDID      8'h90
`define SFID_OP_MDID2     8'h92
`define SFID_OP_MDID4     8'h94
`define SFID_OP_UID       8'h4b
`define SFID_OP_JID       8'h9f
`define SFID_OP_SFDP      8'h5a
`define SFID_OP_SERASE    8'h44
`define SFID_OP_SPROG     8'h42
`define SFID_OPC_BITS     6'h08
`define SFID_ADDR_BITS    6'h18
`define SFID_MODE_BITS    6'h08
`define SFID_QDUMMY_CLKS  6'h04
`define SFID_UID_CLKS     6'h20
`define SFID_SFDP_CLKS    6'h08
`define SFID_SWAP_ADDR    24'h000001
`define SFID_SEC_HI       8'h00
`define SFID_SEC_LO       4'h0
`define SFID_SEC_FIRST    4'h1
`define SFID_SEC_LAST     4'h3
`define SFID_LAST_BYTE    8'hff
`define SFID_ERASED       8'hff
`define SFID_JID_LAST     8'h02
`define SFID_SIG0         8'h53
`define SFID_SIG1         8'h46
`define SFID_SIG2         8'h44
`define SFID_SIG3         8'h50
`endif

/* File: sfid_checker_assertions.sv */
// Pin-level assertions for the ID and security register block.
// Assumes binding onto sfid_top; everything runs in the SYS_CLK domain.
`timescale 1ns/10ps
module sfid_checker (
  // System
  input logic       SYS_CLK,
  input logic       RESET_N,
  // Pins and status
  input logic       SPI_CS_N,
  input logic [3:0] SPI_IO_OE,
  input logic       WRITE_ENABLE_LATCH,
  input logic       BUSY,
  input logic       WEL_CLEAR
);
  logic [8:0] busy_cnt_q;
  logic [8:0] busy_cnt_d;

  // Counts busy cycles; a repetition of 256 would be too slow to unroll
  assign busy_cnt_d = BUSY ? busy_cnt_q + 9'h001 : 9'h000;
  always @(posedge SYS_CLK or negedge RESET_N) begin
    if (!RESET_N)
      busy_cnt_q <= 9'h000;
    else
      busy_cnt_q <= busy_cnt_d;
  end

  default clocking @(posedge SYS_CLK); endclocking
  default disable iff (!RESET_N);

  sequence s_cs_quiet;
    SPI_CS_N [*6];
  endsequence
  sequence s_clr_soon;
    ##[0:1] WEL_CLEAR;
  endsequence

  chk_oe_idle: assert property (s_cs_quiet |-> SPI_IO_OE == 4'h0)
    else $error("lanes driven with chip select high");
  chk_oe_lanes: assert property (SPI_IO_OE inside {4'h0, 4'h2, 4'h3, 4'hf})
    else $error("illegal lane enable pattern");
  chk_oe_needs_cs: assert property ($rose(SPI_IO_OE != 4'h0) |-> !SPI_CS_N)
    else $error("lanes enabled outside a frame");
  chk_busy_len: assert property ($fell(BUSY) |-> busy_cnt_q == 9'h100)
    else $error("busy walk length wrong");
  chk_walk_end: assert property ($fell(BUSY) |-> s_clr_soon)
    else $error("no latch clear after busy walk");
  chk_clr_single: assert property (WEL_CLEAR |=> !WEL_CLEAR)
    else $error("latch clear longer than one cycle");
  chk_clr_cause: assert property (WEL_CLEAR |-> !BUSY && ($past(BUSY) || $past(BUSY, 2)))
    else $error("latch clear without busy walk");
  chk_busy_on_cs: assert property ($rose(BUSY) |-> SPI_CS_N && $past(SPI_CS_N))
    else $error("busy started inside a frame");
  chk_busy_latch: assert property ($rose(BUSY) |-> $past(WRITE_ENABLE_LATCH))
    else $error("busy started with latch low");
  chk_busy_quiet: assert property (BUSY && $past(BUSY, 3) |-> SPI_IO_OE == 4'h0)
    else $error("lanes driven while busy");
endmodule

bind sfid_top sfid_checker sfid_checker_inst (
  .SYS_CLK            (SYS_CLK),
  .RESET_N            (RESET_N),
  .SPI_CS_N           (SPI_CS_N),
  .SPI_IO_OE          (SPI_IO_OE),
  .WRITE_ENABLE_LATCH (WRITE_ENABLE_LATCH),
  .BUSY               (BUSY),
  .WEL_CLEAR          (WEL_CLEAR)
);

/* File: sfid_host_model.sv */
// Behavioural SPI host driving chip select, clock and data lanes.
// Assumes a free-running system clock; SPI clock is 160 ns, idles low.
`timescale 1ns/10ps
module sfid_host_model (
  // System
  input  logic       clk,
  // Pins toward the device
  output logic       spi_clk,
  output logic       spi_cs_n,
  output logic [3:0] spi_io,
  input  logic [3:0] spi_io_out
);
  logic [3:0] last_q;

  initial begin
    spi_clk = 1'b0;
    spi_cs_n = 1'b1;
    spi_io = 4'h0;
    last_q = 4'h0;
  end

  // Sampled late in the high phase, well after the device updates
  task automatic pulse(input logic [3:0] din, output logic [3:0] dout);
    @(posedge clk);
    spi_io <= din;
    last_q = din;
    repeat (3) @(posedge clk);
    spi_clk <= 1'b1;
    repeat (4) @(posedge clk);
    dout = spi_io_out;
    spi_clk <= 1'b0;
  endtask

  // Unused lanes toggle so a stale value can never pass
  task automatic send(input int ln, input int n, input logic [63:0] d);
    logic [3:0] m;
    logic [3:0] o;
    m = 4'((1 << ln) - 1);
    for (int i = n - 1; i >= 0; i--) begin
      pulse((4'(d >> (i * ln)) & m) | (~last_q & ~m), o);
    end
  endtask

  task automatic recv(input int ln, input int n, output logic [63:0] q);
    logic [3:0] m;
    logic [3:0] o;
    m = 4'((1 << ln) - 1);
    q = 64'h0;
    for (int i = 0; i < n; i++) begin
      pulse(~last_q, o);
      q = (q << ln) | 64'(ln == 1 ? {3'h0, o[1]} : o & m);
    end
  endtask

  task automatic start(input logic [7:0] op);
    @(posedge clk);
    spi_cs_n <= 1'b0;
    send(1, 8, 64'(op));
  endtask

  // Chip select stays low across all data until here
  task automatic stop;
    @(posedge clk);
    spi_cs_n <= 1'b1;
    spi_io <= ~last_q;
    repeat (8) @(posedge clk);
  endtask
endmodule

/* File: test_sfid_top.sv */
// Self-checking bench for the ID and security register block.
// Assumes the host model file and the bound checker are compiled first.
`timescale 1ns/10ps
module test_sfid_top;
  localparam logic [7:0]  MFR = 8'h3a;  // Arbitrary value
  localparam logic [7:0]  DEV = 8'h21;  // Arbitrary value
  localparam logic [7:0]  MT  = 8'h77;
  localparam logic [7:0]  CAP = 8'h15;
  localparam logic [63:0] UID = 64'h8899aabbccddeeff;  // Arbitrary value
  logic        sys_clk;
  logic        reset_n;
  logic        spi_clk;
  logic        spi_cs_n;
  logic [3:0]  spi_io;
  logic [3:0]  io_out;
  logic [3:0]  io_oe;
  logic [3:0]  io_pin;
  logic        latch;
  logic [2:0]  lock;
  logic        busy;
  logic        latch_clr;
  logic [7:0]  mode;
  logic [9:0]  rd_addr;
  logic [7:0]  rd_data;
  logic [63:0] q;
  int          num_errors = 0;
  int          compares = 0;

  sfid_top #(
    .MFR_CODE (MFR), .DEV_CODE (DEV), .MEM_TYPE (MT), .CAPACITY (CAP), .UNIQUE_ID (UID)
  ) sfid_top_inst (
    .SYS_CLK (sys_clk), .RESET_N (reset_n), .SPI_CLK (spi_clk), .SPI_CS_N (spi_cs_n),
    .SPI_IO_IN (spi_io), .SPI_IO_OUT (io_out), .SPI_IO_OE (io_oe), .WRITE_ENABLE_LATCH (latch),
    .OTP_LOCK_BITS (lock), .BUSY (busy), .WEL_CLEAR (latch_clr),
    .CONTINUOUS_READ_MODE_BITS (mode), .SECREG_RD_ADDR (rd_addr), .SECREG_RD_DATA (rd_data)
  );
  sfid_host_model host (
    .clk (sys_clk), .spi_clk (spi_clk), .spi_cs_n (spi_cs_n), .spi_io (spi_io),
    .spi_io_out (io_pin)
  );
  // Undriven lanes read back inverted so a stale value cannot pass
  assign io_pin = ~(io_out ^ io_oe);

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  task automatic give_verdict;
    $display("compares %0d mismatches %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  task automatic cmp(input string nm, input logic [63:0] e, input logic [63:0] g);
    compares++;
    if (g !== e) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask

  function automatic logic [63:0] pr(input logic sw);
    return sw ? {32'h0, DEV, MFR, DEV, MFR} : {32'h0, MFR, DEV, MFR, DEV};
  endfunction

  // Window opens a few cycles into the busy walk and covers its end and the clear pulse after it
  task automatic sec(input logic [7:0] op, input logic [23:0] ad, input int nb,
                     input logic [63:0] d, input logic [1:0] e);
    logic [1:0] s;
    s = 2'b00;
    host.start(op);
    host.send(1, 24, 64'(ad));
    if (nb > 0)
      host.send(1, nb, d);
    host.stop();
    repeat (320) begin
      @(posedge sys_clk);
      s = s | {busy, latch_clr};
    end
    cmp("busy and latch clear", 64'(e), 64'(s));
  endtask

  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    rd_addr <= a;
    repeat (3) @(posedge sys_clk);
    cmp("secreg byte", 64'(e), 64'(rd_data));
  endtask

  initial begin
    reset_n = 1'b0;
    latch = 1'b0;
    lock = 3'h0;
    rd_addr = 10'h000;
    repeat (8) @(posedge sys_clk);
    reset_n <= 1'b1;
    repeat (4) @(posedge sys_clk);
    host.start(8'h9f);
    host.recv(1, 48, q);
    host.stop();
    cmp("jedec id", {16'h0, MFR, MT, CAP, MFR, MT, CAP}, q);
    for (int a = 0; a < 2; a++) begin
      host.start(8'h90);
      host.send(1, 24, 64'(a));
      host.recv(1, 32, q);
      cmp("single enables", 64'h2, 64'(io_oe));
      host.stop();
      cmp("single id", pr(a[0]), q);
      host.start(8'h92);
      host.send(2, 16, {a[23:0], 8'hf5});
      host.recv(2, 16, q);
      cmp("dual enables", 64'h3, 64'(io_oe));
      host.stop();
      cmp("dual id", pr(a[0]), q);
      cmp("mode bits", 64'hf5, 64'(mode));
      host.start(8'h94);
      host.send(4, 12, {a[23:0], 8'hfa, 16'h0});
      host.recv(4, 8, q);
      cmp("quad enables", 64'hf, 64'(io_oe));
      host.stop();
      cmp("quad id", pr(a[0]), q);
    end
    host.start(8'h4b);
    host.send(1, 32, 64'h0);
    host.recv(1, 64, q);
    host.stop();
    cmp("unique id", UID, q);
    host.start(8'h5a);
    host.send(1, 32, 64'h200);
    host.recv(1, 32, q);
    host.stop();
    cmp("param bytes", 64'h4450ffff, q);
    $display("test id reads done");
    sec(8'h44, 24'h001000, 0, 0, 2'b00);
    latch <= 1'b1;
    sec(8'h44, 24'h001000, 1, 0, 2'b00);
    sec(8'h44, 24'h004000, 0, 0, 2'b00);
    sec(8'h44, 24'h0020a7, 0, 0, 2'b11);
    rd(10'h100, 8'hff);
    sec(8'h42, 24'h0020ff, 16, 64'ha53c, 2'b11);
    rd(10'h1ff, 8'ha5);
    rd(10'h100, 8'h3c);
    sec(8'h42, 24'h0020ff, 8, 64'h0f, 2'b11);
    rd(10'h1ff, 8'h05);
    $display("test erase and program done");
    lock <= 3'b010;
    sec(8'h44, 24'h002000, 0, 0, 2'b00);
    sec(8'h42, 24'h002000, 8, 0, 2'b00);
    rd(10'h100, 8'h3c);
    $display("test lock done");
    give_verdict();
  end

  initial begin
    repeat (40000) @(posedge sys_clk);
    num_errors++;
    give_verdict();
  end
endmodule
